// >>> include/wtw_cfg.svh
`ifndef WTW_CFG_SVH
`define WTW_CFG_SVH
// sfr addresses of the timer interface
`define WTW_ADDR_DATA_HIGH 8'hab
`define WTW_ADDR_DATA_LOW 8'hac
`define WTW_ADDR_COMMAND 8'had
`define WTW_ADDR_DIVIDER 8'hb5
// reset values
`define WTW_DIVIDER_RESET 8'h1d
`define WTW_DATA_RESET 8'h00
`define WTW_COMMAND_RESET 4'h0
// command register fields
`define WTW_CMD_BUSY_BIT 4
`define WTW_CMD_READ_WD 4'h0
`define WTW_CMD_WRITE_WD 4'h8
`define WTW_CMD_READ_LATCH 4'h2
`define WTW_CMD_WRITE_LATCH 4'ha
`define WTW_CMD_READ_COUNT 4'h3
`define WTW_CMD_STOP_WAKEUP 4'hb
// startup lengths in low-power oscillator cycles
`define WTW_POR_STARTUP 8'd14
`define WTW_WD_STARTUP 8'd12
`endif

// >>> include/wtw_pkg.sv
package wtw_pkg;
	// sfr bus request from the cpu
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} wtw_sfr_req_type;
	// interface unit states
	typedef enum logic [1:0] {
		WTW_IDLE,
		WTW_WAIT_TICK,
		WTW_DONE
	} wtw_state_type;
	// startup sequencer states
	typedef enum logic [1:0] {
		WTW_RUN,
		WTW_START
	} wtw_boot_type;
endpackage : wtw_pkg

// >>> core/wtw_timer.sv
`timescale 1ns/10ps
`include "wtw_cfg.svh"
// Contract
// [RL1] tick = low-power osc divided by one plus divider; divider resets to 1d
// [RL2] wakeup and watchdog counters both step once per tick
// [RL3] wakeup is 16 bit down counter; at zero it flags and reloads from latch
// [RL4] wakeup counter disabled after reset, enabled by first latch write
// [RL5] each latch write reloads the wakeup counter from the latch
// [RL6] command 1011 stops the wakeup counter, no data moved
// [RL7] first wakeup after n+1..n+2 ticks, then every n+1 ticks
// [RL8] wakeup sets the poll flag and requests interrupt when enabled
// [RL9] wakeup restarts a stopped main oscillator regardless of enable
// [RL10] watchdog armed on first command write; only reset disarms it
// [RL11] loaded watchdog counts down and resets the chip at zero
// [RL12] command bit 4 reads busy; bits 3..0 read and write
// [RL13] codes: 0000/1000 wd, 0010/1010 latch, 0011 counter read; 16 bits
// [RL14] software writes high byte, low byte, then command when not busy
// [RL15] software reads: command, wait not busy, then high and low byte
// [RL16] software waits for not busy before touching clock power control
// [RL17] capture trigger input carries the low-power osc at half frequency
// [RL18] power-on start runs about 14 low-power osc cycles, then runs
// [RL19] watchdog reset start takes 12 low-power osc cycles
// [RL20] busy holds from command write until the slow-side transfer is done
module wtw_timer
	import wtw_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	input wire logic clk_i, // system clock, 50 mhz
	input wire logic resetn_i, // synchronous reset, active low
	input wire logic clk_en_i, // freezes all state while low
	input wire wtw_sfr_req_type sfr_i, // sfr access from the cpu
	input wire logic osc_lp_i, // low-power oscillator level
	input wire logic wakeup_irq_enable_i, // cpu wakeup interrupt enable
	input wire logic wakeup_irq_clear_i, // software clears the poll flag
	input wire logic main_osc_stopped_i, // main oscillator is in power down
	output logic [7:0] sfr_rdata_o, // read data for the sfr bus
	output logic wakeup_irq_flag_o, // sticky wakeup flag
	output logic wakeup_irq_o, // wakeup interrupt request
	output logic osc_restart_o, // pulse restarting the main oscillator
	output logic capture_trigger_input_o, // low-power osc divided by two
	output logic chip_reset_o, // holds the chip in reset during startup
	output logic wd_reset_cause_o // last reset came from the watchdog
);
	// elaboration check: the sfr data path is exactly two bytes wide
	if (COUNT_W != 16) begin : g_bad_width
		$error("wtw_timer: counters must be 16 bits wide");
	end

	logic [7:0] data_high_reg;
	logic [7:0] data_low_reg;
	logic [3:0] command_reg;
	logic [7:0] divider_reg;
	logic [7:0] div_count_reg;
	logic osc_last_reg;
	logic tick_reg;
	logic half_reg;
	wtw_state_type state_reg;
	logic [COUNT_W-1:0] latch_reg;
	logic [COUNT_W-1:0] wake_count_reg;
	logic wake_on_reg;
	logic wake_event_reg;
	logic [COUNT_W-1:0] wd_count_reg;
	logic wd_armed_reg;
	logic wd_fire_reg;
	wtw_boot_type boot_reg;
	logic [7:0] boot_count_reg;
	logic [7:0] boot_len_reg;
	logic flag_reg;
	logic [7:0] rdata_reg;
	logic osc_edge;
	logic cmd_wr;
	logic busy;
	logic sfr_init;

	// watchdog fires on the tick that would take the count to zero
	localparam logic [COUNT_W-1:0] WD_LAST = COUNT_W'(1);

	// true when the cpu writes the given sfr address
	function automatic logic sfr_hit(input wtw_sfr_req_type r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction : sfr_hit

	// done cycle of a transfer with the given command code
	function automatic logic done_cmd(input wtw_state_type s, input logic [3:0] c,
		input logic [3:0] code);
		return (s == WTW_DONE) && (c == code);
	endfunction : done_cmd

	// the two data bytes as one word, high byte first
	function automatic logic [15:0] data_word(input logic [7:0] hi, input logic [7:0] lo);
		return {hi, lo};
	endfunction : data_word

	// one step down of a tick counter
	function automatic logic [COUNT_W-1:0] count_down(input logic [COUNT_W-1:0] v);
		return v - COUNT_W'(1);
	endfunction : count_down

	assign osc_edge = osc_lp_i && !osc_last_reg;
	assign cmd_wr = sfr_hit(sfr_i, `WTW_ADDR_COMMAND);
	assign busy = (state_reg != WTW_IDLE); // [RL20]
	assign sfr_init = (boot_reg == WTW_START); // startup restores the sfr reset values

	// oscillator edge detect; reset high so a level already high is no edge
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			osc_last_reg <= 1'b1;
		end else if (clk_en_i) begin
			osc_last_reg <= osc_lp_i;
		end
	end

	// half-rate copy of the oscillator for the capture input
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			half_reg <= 1'b0;
		end else if (clk_en_i && osc_edge) begin
			half_reg <= !half_reg; // [RL17]
		end
	end

	// divider value, written by the cpu, restored by every startup
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			divider_reg <= `WTW_DIVIDER_RESET; // [RL1]
		end else if (clk_en_i) begin
			if (sfr_init) begin
				divider_reg <= `WTW_DIVIDER_RESET; // [RL19]
			end else if (sfr_hit(sfr_i, `WTW_ADDR_DIVIDER)) begin
				divider_reg <= sfr_i.wdata;
			end
		end
	end

	// tick counter: one tick every divider+1 oscillator periods
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			div_count_reg <= 8'h00;
			tick_reg <= 1'b0;
		end else if (clk_en_i) begin
			tick_reg <= 1'b0;
			if (osc_edge) begin
				if (div_count_reg >= divider_reg) begin
					div_count_reg <= 8'h00;
					tick_reg <= 1'b1; // [RL1]
				end else begin
					div_count_reg <= div_count_reg + 8'h01;
				end
			end
		end
	end

	// data bytes; read commands load them at the end of the transfer
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			data_high_reg <= `WTW_DATA_RESET;
			data_low_reg <= `WTW_DATA_RESET;
		end else if (clk_en_i) begin
			if (sfr_hit(sfr_i, `WTW_ADDR_DATA_HIGH)) begin
				data_high_reg <= sfr_i.wdata;
			end
			if (sfr_hit(sfr_i, `WTW_ADDR_DATA_LOW)) begin
				data_low_reg <= sfr_i.wdata;
			end
			if (state_reg == WTW_DONE) begin
				case (command_reg) // [RL13]
					`WTW_CMD_READ_WD: {data_high_reg, data_low_reg} <= wd_count_reg;
					`WTW_CMD_READ_LATCH: {data_high_reg, data_low_reg} <= latch_reg;
					`WTW_CMD_READ_COUNT: {data_high_reg, data_low_reg} <= wake_count_reg;
					default: ;
				endcase
			end
			if (sfr_init) begin
				data_high_reg <= `WTW_DATA_RESET; // [RL19]
				data_low_reg <= `WTW_DATA_RESET;
			end
		end
	end

	// command register and the transfer into the slow tick domain
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			command_reg <= `WTW_COMMAND_RESET;
			state_reg <= WTW_IDLE;
		end else if (clk_en_i) begin
			case (state_reg)
				WTW_IDLE: begin
					if (cmd_wr) begin
						command_reg <= sfr_i.wdata[3:0]; // [RL12]
						state_reg <= WTW_WAIT_TICK; // [RL20]
					end
				end
				WTW_WAIT_TICK: begin
					if (osc_edge) begin
						state_reg <= WTW_DONE;
					end
				end
				WTW_DONE: state_reg <= WTW_IDLE; // [RL20]
				default: state_reg <= WTW_IDLE;
			endcase
			if (sfr_init) begin
				command_reg <= `WTW_COMMAND_RESET; // [RL19]
				state_reg <= WTW_IDLE;
			end
		end
	end

	// wakeup latch and auto-reloading down counter
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			latch_reg <= '0;
			wake_count_reg <= '0;
			wake_on_reg <= 1'b0; // [RL4]
			wake_event_reg <= 1'b0;
		end else if (clk_en_i) begin
			wake_event_reg <= 1'b0;
			if (done_cmd(state_reg, command_reg, `WTW_CMD_WRITE_LATCH)) begin
				latch_reg <= data_word(data_high_reg, data_low_reg);
				wake_count_reg <= data_word(data_high_reg, data_low_reg); // [RL5]
				wake_on_reg <= 1'b1; // [RL4]
			end else if (done_cmd(state_reg, command_reg, `WTW_CMD_STOP_WAKEUP)) begin
				wake_on_reg <= 1'b0; // [RL6]
			end else if (wake_on_reg && tick_reg) begin // [RL2]
				if (wake_count_reg == '0) begin
					wake_count_reg <= latch_reg; // [RL3] [RL7]
					wake_event_reg <= 1'b1;
				end else begin
					wake_count_reg <= count_down(wake_count_reg);
				end
			end
		end
	end

	// sticky wakeup flag; an event in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			flag_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (wake_event_reg) begin
				flag_reg <= 1'b1; // [RL8] set wins over clear
			end else if (wakeup_irq_clear_i) begin
				flag_reg <= 1'b0;
			end
		end
	end

	// interrupt request while the cpu interrupt is enabled
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wakeup_irq_o <= 1'b0;
		end else if (clk_en_i) begin
			wakeup_irq_o <= (flag_reg || wake_event_reg) && wakeup_irq_enable_i; // [RL8]
		end
	end

	// restart pulse for a stopped main oscillator, enable ignored
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			osc_restart_o <= 1'b0;
		end else if (clk_en_i) begin
			osc_restart_o <= wake_event_reg && main_osc_stopped_i; // [RL9]
		end
	end

	// watchdog: armed by the first command write, counts down per tick
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wd_count_reg <= '0;
			wd_armed_reg <= 1'b0;
			wd_fire_reg <= 1'b0;
		end else if (clk_en_i) begin
			wd_fire_reg <= 1'b0;
			if (boot_reg == WTW_START) begin
				wd_armed_reg <= 1'b0; // watchdog reset disarms it too
				wd_count_reg <= '0;
			end else begin
				if (cmd_wr) begin
					wd_armed_reg <= 1'b1; // [RL10]
				end
				if (done_cmd(state_reg, command_reg, `WTW_CMD_WRITE_WD)) begin
					wd_count_reg <= data_word(data_high_reg, data_low_reg); // [RL11]
				end else if (wd_armed_reg && tick_reg) begin // [RL2]
					if (wd_count_reg == '0 || wd_count_reg == WD_LAST) begin
						wd_fire_reg <= 1'b1; // [RL11]
						wd_count_reg <= '0;
					end else begin
						wd_count_reg <= count_down(wd_count_reg);
					end
				end
			end
		end
	end

	// startup sequencer: chip held in reset for a count of osc cycles
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			boot_reg <= WTW_START;
			boot_len_reg <= `WTW_POR_STARTUP; // [RL18]
			boot_count_reg <= 8'h00;
			chip_reset_o <= 1'b1;
			wd_reset_cause_o <= 1'b0;
		end else if (clk_en_i) begin
			case (boot_reg)
				WTW_RUN: begin
					chip_reset_o <= 1'b0;
					if (wd_fire_reg) begin
						boot_reg <= WTW_START;
						boot_len_reg <= `WTW_WD_STARTUP; // [RL19]
						boot_count_reg <= 8'h00;
						chip_reset_o <= 1'b1;
						wd_reset_cause_o <= 1'b1;
					end
				end
				WTW_START: begin
					chip_reset_o <= 1'b1;
					if (osc_edge) begin
						if (boot_count_reg + 8'h01 >= boot_len_reg) begin
							boot_reg <= WTW_RUN; // [RL18] [RL19]
							chip_reset_o <= 1'b0;
						end else begin
							boot_count_reg <= boot_count_reg + 8'h01;
						end
					end
				end
				default: boot_reg <= WTW_START;
			endcase
		end
	end

	// registered sfr read data
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_reg <= 8'h00;
		end else if (clk_en_i) begin
			case (sfr_i.addr)
				`WTW_ADDR_DATA_HIGH: rdata_reg <= data_high_reg;
				`WTW_ADDR_DATA_LOW: rdata_reg <= data_low_reg;
				`WTW_ADDR_COMMAND: rdata_reg <= {3'h0, busy, command_reg}; // [RL12]
				`WTW_ADDR_DIVIDER: rdata_reg <= divider_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	assign sfr_rdata_o = rdata_reg;
	assign wakeup_irq_flag_o = flag_reg;
	assign capture_trigger_input_o = half_reg;
endmodule : wtw_timer

// >>> testbench/wtw_timer_assertions.sv
`timescale 1ns/10ps
module wtw_chk
	import wtw_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic resetn_i, // reset, low
	input wire logic clk_en_i, // enable
	input wire wtw_sfr_req_type sfr_i, // sfr request
	input wire logic osc_lp_i, // slow osc
	input wire logic wakeup_irq_enable_i, // irq enable
	input wire logic wakeup_irq_clear_i, // flag clear
	input wire logic main_osc_stopped_i, // osc stopped
	input wire logic [7:0] sfr_rdata_o, // read data
	input wire logic wakeup_irq_flag_o, // wakeup flag
	input wire logic wakeup_irq_o, // irq request
	input wire logic osc_restart_o, // restart pulse
	input wire logic capture_trigger_input_o, // half rate osc
	input wire logic chip_reset_o, // chip reset
	input wire logic wd_reset_cause_o // watchdog cause
);
	// one clock domain, checks quiet in reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	cap_toggle_a: assert property ($rose(osc_lp_i) && clk_en_i |-> ##[1:3] $changed(capture_trigger_input_o))
		else $error("capture output missed an osc edge");
	irq_mask_a: assert property (wakeup_irq_o |-> $past(wakeup_irq_enable_i))
		else $error("irq raised while disabled");
	irq_flag_a: assert property (wakeup_irq_flag_o && wakeup_irq_enable_i |=> wakeup_irq_o)
		else $error("enabled flag gave no irq");
	restart_pulse_a: assert property (osc_restart_o |=> !osc_restart_o)
		else $error("restart longer than one cycle");
	restart_cause_a: assert property (osc_restart_o |-> $past(main_osc_stopped_i))
		else $error("restart while osc running");
	unmapped_zero_a: assert property (sfr_i.addr == 8'h10 |=> sfr_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	cmd_upper_a: assert property (sfr_i.addr == 8'had |=> sfr_rdata_o[7:5] == 3'h0)
		else $error("command upper bits not zero");
	reset_vals_a: assert property ($rose(resetn_i) |-> chip_reset_o && sfr_rdata_o == 8'h00)
		else $error("bad values out of reset");
	cause_reset_a: assert property ($rose(wd_reset_cause_o) |-> ##[0:2] chip_reset_o)
		else $error("watchdog cause without reset");
	flag_sticky_a: assert property (wakeup_irq_flag_o && !wakeup_irq_clear_i &&
		!chip_reset_o |=> wakeup_irq_flag_o || chip_reset_o)
		else $error("flag dropped without clear");
	cover property (wakeup_irq_o);
	cover property (osc_restart_o);
	cover property ($rose(wd_reset_cause_o));
endmodule : wtw_chk
bind wtw_timer wtw_chk chk (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
	.sfr_i(sfr_i), .osc_lp_i(osc_lp_i), .wakeup_irq_enable_i(wakeup_irq_enable_i),
	.wakeup_irq_clear_i(wakeup_irq_clear_i), .main_osc_stopped_i(main_osc_stopped_i),
	.sfr_rdata_o(sfr_rdata_o), .wakeup_irq_flag_o(wakeup_irq_flag_o), .wakeup_irq_o(wakeup_irq_o),
	.osc_restart_o(osc_restart_o), .capture_trigger_input_o(capture_trigger_input_o),
	.chip_reset_o(chip_reset_o), .wd_reset_cause_o(wd_reset_cause_o));

// >>> testbench/wtw_timer_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
	$display("ERROR %0t got %h exp %h", $time, a, e); end end
module wtw_timer_tb
	import wtw_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, osc = 1'b0, en = 1'b0, clr = 1'b0, stop = 1'b0;
	wtw_sfr_req_type sfr = '0;
	logic [7:0] rdata, d;
	logic flag, irq, rst_o, cause, restart, seen = 1'b0;
	int err_total = 0, n_checks = 0, osc_n = 0, cyc = 0, t0;
	logic [16:0] rows [8] = '{17'h0ab00, 17'h0ac00, 17'h0ad00, 17'h0b51d, 17'h01000,
		17'h1b500, 17'h1ab5a, 17'h1aca5};
	wtw_timer dut (.clk_i(clk), .resetn_i(rstn), .clk_en_i(1'b1), .sfr_i(sfr), .osc_lp_i(osc),
		.wakeup_irq_enable_i(en), .wakeup_irq_clear_i(clr), .main_osc_stopped_i(stop),
		.sfr_rdata_o(rdata), .wakeup_irq_flag_o(flag), .wakeup_irq_o(irq),
		.osc_restart_o(restart), .capture_trigger_input_o(), .chip_reset_o(rst_o),
		.wd_reset_cause_o(cause));
	always #10 clk = ~clk;
	// slow osc of 16 clocks, restart catcher, hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		osc <= cyc[3];
		if (restart) seen <= 1'b1;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end
	always @(posedge osc) osc_n++;
	task summarize;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) sfr <= '{1'b1, 1'b0, a, v};
		@(posedge clk) sfr.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk) sfr <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge clk);
		@(negedge clk) d = rdata;
	endtask : rd
	task automatic wait_lvl(ref logic s, input logic v);
		for (int i = 0; i < 2000 && s !== v; i++) @(negedge clk);
	endtask : wait_lvl
	// poll busy until the slow side is done
	task idle;
		for (int i = 0; i < 100; i++) begin
			rd(8'had);
			if (d[4] === 1'b0) break;
		end
		`CHK(d[4], 1'b0)
	endtask : idle
	// full transfer, command issued just after an osc edge
	task load(input logic [3:0] c, input logic [15:0] v);
		wr(8'hab, v[15:8]);
		wr(8'hac, v[7:0]);
		@(posedge osc);
		wr(8'had, {4'h0, c});
		rd(8'had);
		`CHK(d, {4'h1, c})
		idle();
	endtask : load
	task pulse_clr;
		@(posedge clk) clr <= 1'b1;
		@(posedge clk) clr <= 1'b0;
		@(negedge clk);
	endtask : pulse_clr
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		t0 = osc_n;
		wait_lvl(rst_o, 1'b0);
		`CHK((osc_n - t0) inside {[14:15]}, 1'b1)
		for (int i = 0; i < 8; i++) begin
			if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
			rd(rows[i][15:8]);
			`CHK(d, rows[i][7:0])
		end
		load(4'h8, 16'hffff);
		load(4'h0, 16'h0000);
		rd(8'hab);
		`CHK(d, 8'hff)
		@(posedge clk) stop <= 1'b1;
		load(4'ha, 16'h0003);
		t0 = osc_n;
		wait_lvl(flag, 1'b1);
		`CHK((osc_n - t0) inside {[4:5]}, 1'b1)
		t0 = osc_n;
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0)
		`CHK(seen, 1'b1)
		@(posedge clk) en <= 1'b1;
		pulse_clr();
		wait_lvl(flag, 1'b1);
		`CHK(osc_n - t0, 4)
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b1)
		load(4'h2, 16'h0000);
		rd(8'hac);
		`CHK(d, 8'h03)
		load(4'h3, 16'h0000);
		rd(8'hac);
		`CHK(d <= 8'h03, 1'b1)
		load(4'hb, 16'h0000);
		pulse_clr();
		repeat (12) @(posedge osc);
		`CHK(flag, 1'b0)
		load(4'h8, 16'h0005);
		t0 = osc_n;
		wait_lvl(rst_o, 1'b1);
		`CHK((osc_n - t0) inside {[5:6]}, 1'b1)
		`CHK(cause, 1'b1)
		t0 = osc_n;
		wait_lvl(rst_o, 1'b0);
		`CHK(osc_n - t0, 12)
		rd(8'hb5);
		`CHK(d, 8'h1d)
		idle();
		wr(8'hb6, 8'h00);
		rd(8'hb6);
		`CHK(d, 8'h00)
		summarize();
	end
endmodule : wtw_timer_tb
